// [logic/usfl_consts.vh]
// constants of the uart status flag logic: offsets, fields, resets, counts
`ifndef USFL_CONSTS_VH
`define USFL_CONSTS_VH
// register byte offsets
`define USFL_OFS_STAT   8'h00
`define USFL_OFS_CTRL   8'h04
`define USFL_OFS_CFG    8'h08
`define USFL_OFS_DLOW   8'h0C
`define USFL_OFS_DHIGH  8'h10
`define USFL_OFS_BAUD   8'h14
// status bit positions
`define USFL_ST_TX_HOLDING_EMPTY_FLAG    7
`define USFL_ST_TC      6
`define USFL_ST_RX_HOLDING_FULL_FLAG    5
`define USFL_ST_IDLE    4
`define USFL_ST_OR      3
`define USFL_ST_NF      2
`define USFL_ST_FE      1
`define USFL_ST_PF      0
// control bit positions
`define USFL_CT_TIE     7
`define USFL_CT_TX_DONE_IRQ_ENABLE    6
`define USFL_CT_RIE     5
`define USFL_CT_IDLE_LINE_IRQ_ENABLE    4
`define USFL_CT_TE      3
`define USFL_CT_RE      2
`define USFL_CT_RWU     1
`define USFL_CT_SBK     0
// config bit positions
`define USFL_CF_NINE    2
`define USFL_CF_PEN     1
`define USFL_CF_PODD    0
// data high bit positions
`define USFL_DH_R8      7
`define USFL_DH_T8      6
// reset values
`define USFL_STAT_RST   8'hC0
`define USFL_CTRL_RST   8'h00
`define USFL_CFG_RST    3'h0
`define USFL_BAUD_RST   16'h0004
// frame lengths in bits and oversampling
`define USFL_LEN8       4'hA
`define USFL_LEN9       4'hB
`define USFL_OVS_LAST   4'hF
`define USFL_SMP_A      4'h7
`define USFL_SMP_B      4'h8
`define USFL_SMP_C      4'h9
`endif

// [logic/usfl_tx_shift.v]
// transmit shifter: sends one prepared frame lsb first
`timescale 1ns/1ps
`default_nettype none
`include "usfl_consts.vh"
module usfl_tx_shift (
    input  wire        clk_in,
    input  wire        rst_n_in,
    input  wire        tick_in,
    input  wire        load_in,
    input  wire [10:0] word_in,
    input  wire [3:0]  len_in,
    output reg         busy_out,
    output reg         txd_out
);
    reg [10:0] sh_r;   // frame bits still to go
    reg [3:0]  left_r; // bits left in frame
    reg [3:0]  ph_r;   // oversample phase
    // one bit per sixteen ticks; line high when not busy
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sh_r     <= 11'h7FF;
            left_r   <= 4'h0;
            ph_r     <= 4'h0;
            busy_out <= 1'b0;
            txd_out  <= 1'b1;
        end else if (load_in && !busy_out) begin
            sh_r     <= word_in;
            left_r   <= len_in;
            ph_r     <= 4'h0;
            busy_out <= 1'b1;
            txd_out  <= word_in[0];
        end else if (busy_out && tick_in) begin
            if (ph_r == `USFL_OVS_LAST) begin
                ph_r <= 4'h0;
                if (left_r == 4'h1) begin
                    busy_out <= 1'b0;
                    txd_out  <= 1'b1;
                end else begin
                    sh_r    <= {1'b1, sh_r[10:1]};
                    left_r  <= left_r - 4'h1;
                    txd_out <= sh_r[1];
                end
            end else begin
                ph_r <= ph_r + 4'h1;
            end
        end
    end
endmodule // usfl_tx_shift
`default_nettype wire

// [logic/usfl_rx_shift.v]
// receive shifter: majority sampling, noise, stop check, idle count
`timescale 1ns/1ps
`default_nettype none
`include "usfl_consts.vh"
module usfl_rx_shift (
    input  wire       clk_in,
    input  wire       rst_n_in,
    input  wire       tick_in,
    input  wire       en_in,
    input  wire       nine_in,
    input  wire       rxd_in,
    output reg        done_out,
    output reg  [8:0] data_out,
    output reg        stop_ok_out,
    output reg        noise_out,
    output reg        idle_out
);
    reg       run_r;  // frame in progress
    reg [3:0] ph_r;   // oversample phase
    reg [3:0] bitn_r; // bit index in frame
    reg [3:0] ones_r; // consecutive idle ones
    reg [1:0] smp_r;  // first two centre samples of this bit
    reg [8:0] dat_r;  // shifted data
    reg       nz_r;   // noise seen this frame
    wire [3:0] len_w = nine_in ? `USFL_LEN9 : `USFL_LEN8;
    // third sample is the live pin; only this bit's samples vote, so an edge never reads as noise
    wire       maj_w = (smp_r[1] & smp_r[0]) | (smp_r[1] & rxd_in) | (smp_r[0] & rxd_in);
    wire       nzb_w = !((smp_r[1] == smp_r[0]) && (smp_r[0] == rxd_in));
    // frame and idle sequencing
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            run_r       <= 1'b0;
            ph_r        <= 4'h0;
            bitn_r      <= 4'h0;
            ones_r      <= 4'h0;
            smp_r       <= 2'h3;
            dat_r       <= 9'h000;
            nz_r        <= 1'b0;
            done_out    <= 1'b0;
            data_out    <= 9'h000;
            stop_ok_out <= 1'b0;
            noise_out   <= 1'b0;
            idle_out    <= 1'b0;
        end else begin
            done_out <= 1'b0;
            idle_out <= 1'b0;
            if (tick_in) begin
                ph_r <= ph_r + 4'h1;
                if (!run_r) begin
                    if (en_in && !rxd_in) begin
                        run_r  <= 1'b1;
                        ph_r   <= 4'h1;
                        bitn_r <= 4'h0;
                        nz_r   <= 1'b0;
                        ones_r <= 4'h0;
                    end else if (ph_r == `USFL_OVS_LAST && ones_r != len_w) begin
                        // idle counted from the stop bit onward
                        ones_r   <= rxd_in ? ones_r + 4'h1 : 4'h0;
                        idle_out <= rxd_in && (ones_r == len_w - 4'h1);
                    end
                end else if (ph_r == `USFL_SMP_A || ph_r == `USFL_SMP_B) begin
                    smp_r <= {smp_r[0], rxd_in};
                end else if (ph_r == `USFL_SMP_C) begin
                    bitn_r <= bitn_r + 4'h1;
                    nz_r   <= nz_r | nzb_w;
                    if (bitn_r == 4'h0 && maj_w) begin
                        run_r <= 1'b0; // false start
                    end else if (bitn_r == len_w - 4'h1) begin
                        run_r       <= 1'b0;
                        ph_r        <= 4'h0;
                        ones_r      <= maj_w ? 4'h1 : 4'h0;
                        done_out    <= 1'b1;
                        stop_ok_out <= maj_w;
                        noise_out   <= nz_r | nzb_w;
                        data_out    <= nine_in ? dat_r : {1'b0, dat_r[8:1]};
                    end else if (bitn_r != 4'h0) begin
                        dat_r <= {maj_w, dat_r[8:1]};
                    end
                end
            end
        end
    end
endmodule // usfl_rx_shift
`default_nettype wire

// [logic/usfl_top.v]
// serial port status flags with ahb-lite register slave
//
// The implementer's own choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "usfl_consts.vh"
module usfl_top (
    input  wire        sys_clk_in,
    input  wire        rst_n_in,
    input  wire        hsel_in,
    input  wire [7:0]  haddr_in,
    input  wire [1:0]  htrans_in,
    input  wire        hwrite_in,
    input  wire [2:0]  hsize_in,
    input  wire [31:0] hwdata_in,
    input  wire        hready_in,
    output reg  [31:0] hrdata_out,
    output wire        hreadyout_out,
    output wire        hresp_out,
    input  wire        rxd_in,
    output wire        txd_out,
    output wire        irq_req_out
);
    // word index match, shared by address and data phase decode
    function sel;
        input [7:0] a;
        input [7:0] o;
        begin
            sel = (a[7:2] == o[7:2]);
        end
    endfunction

    // reset release through two flops
    reg rst_meta_r;   // first stage, read by second only
    reg rst_sync_n_r; // released reset used everywhere
    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_r   <= 1'b0;
            rst_sync_n_r <= 1'b0;
        end else begin
            rst_meta_r   <= 1'b1;
            rst_sync_n_r <= rst_meta_r;
        end
    end

    // software registers
    reg [7:0]  ctrl_r;    // enables, tx/rx enable, standby, break
    reg [2:0]  cfg_r;     // format, parity enable, parity odd
    reg [15:0] baud_r;    // sixteen-times tick divisor
    reg [8:0]  tx_hold_r; // queued character incl ninth bit
    reg [8:0]  rx_data_r; // received character incl ninth bit
    reg        tx_full_r; // holding register awaits shifter
    reg        pre_r;     // idle preamble queued
    reg        te_d_r;    // transmit enable last cycle
    // status flags
    reg tx_holding_empty_flag_r, tc_r, rx_holding_full_flag_r, idle_r, or_r, nf_r, fe_r, pf_r;
    reg [7:0] armed_r;    // flags seen set by a status read
    reg       idle_ok_r;  // idle may be flagged again
    // bus data phase
    reg       wr_pend_r;  // write data expected this cycle
    reg [7:0] wa_r;       // captured write address
    // baud tick
    reg [15:0] div_r;     // divider count
    reg        tick_r;    // one-cycle sixteen-times enable

    wire te_w   = ctrl_r[`USFL_CT_TE];
    wire re_w   = ctrl_r[`USFL_CT_RE];
    wire rwu_w  = ctrl_r[`USFL_CT_RWU];
    wire sbk_w  = ctrl_r[`USFL_CT_SBK];
    wire nine_w = cfg_r[`USFL_CF_NINE];
    wire pen_w  = cfg_r[`USFL_CF_PEN];
    wire podd_w = cfg_r[`USFL_CF_PODD];
    wire [7:0] stat_w = {tx_holding_empty_flag_r, tc_r, rx_holding_full_flag_r, idle_r, or_r, nf_r, fe_r, pf_r};

    // zero wait states, always okay
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;

    // transfer decode
    wire acc_w   = hsel_in && htrans_in[1] && hready_in;
    wire rd_w    = acc_w && !hwrite_in;
    wire st_rd_w = rd_w && sel(haddr_in, `USFL_OFS_STAT);
    wire dl_rd_w = rd_w && sel(haddr_in, `USFL_OFS_DLOW);
    wire dl_wr_w = wr_pend_r && sel(wa_r, `USFL_OFS_DLOW);
    wire dh_wr_w = wr_pend_r && sel(wa_r, `USFL_OFS_DHIGH);
    wire ct_wr_w = wr_pend_r && sel(wa_r, `USFL_OFS_CTRL);
    wire cf_wr_w = wr_pend_r && sel(wa_r, `USFL_OFS_CFG);
    wire bd_wr_w = wr_pend_r && sel(wa_r, `USFL_OFS_BAUD);

    // armed clears: status read first, then the data access
    wire clr_tx_holding_empty_flag_w = dl_wr_w && armed_r[`USFL_ST_TX_HOLDING_EMPTY_FLAG];
    wire clr_tc_w   = dl_wr_w && armed_r[`USFL_ST_TC];
    wire clr_rx_holding_full_flag_w = dl_rd_w && armed_r[`USFL_ST_RX_HOLDING_FULL_FLAG];
    wire clr_idle_w = dl_rd_w && armed_r[`USFL_ST_IDLE];
    wire clr_or_w   = dl_rd_w && armed_r[`USFL_ST_OR];
    wire clr_nf_w   = dl_rd_w && armed_r[`USFL_ST_NF];
    wire clr_fe_w   = dl_rd_w && armed_r[`USFL_ST_FE];
    wire clr_pf_w   = dl_rd_w && armed_r[`USFL_ST_PF];

    // baud divider: a zero divisor stops both shifters
    always @(posedge sys_clk_in or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            div_r  <= 16'h0000;
            tick_r <= 1'b0;
        end else if (baud_r == 16'h0000) begin
            div_r  <= 16'h0000;
            tick_r <= 1'b0;
        end else if (div_r >= baud_r - 16'h0001) begin
            div_r  <= 16'h0000;
            tick_r <= 1'b1;
        end else begin
            div_r  <= div_r + 16'h0001;
            tick_r <= 1'b0;
        end
    end

    // transmit side: pick preamble, then break, then data
    wire       tx_busy_w;           // shifter sending
    wire       tx_txd_w;            // shifter line level
    wire [3:0] len_w = nine_w ? `USFL_LEN9 : `USFL_LEN8;
    // parity bit zero when the ones count matches the type
    wire par8_w = (^tx_hold_r[6:0]) ^ podd_w;
    wire par9_w = (^tx_hold_r[7:0]) ^ podd_w;
    wire hi8_w  = pen_w ? par8_w : tx_hold_r[7];
    wire hi9_w  = pen_w ? par9_w : tx_hold_r[8];
    wire [10:0] dword_w = nine_w ? {1'b1, hi9_w, tx_hold_r[7:0], 1'b0}
                                 : {2'b11, hi8_w, tx_hold_r[6:0], 1'b0};
    wire        go_w    = te_w && !tx_busy_w && (pre_r || sbk_w || tx_full_r);
    wire        dgo_w   = go_w && !pre_r && !sbk_w;  // data frame loads
    wire [10:0] word_w  = pre_r ? 11'h7FF : (sbk_w ? 11'h000 : dword_w);

    usfl_tx_shift u_tx (
        .clk_in   (sys_clk_in),
        .rst_n_in (rst_sync_n_r),
        .tick_in  (tick_r),
        .load_in  (go_w),
        .word_in  (word_w),
        .len_in   (len_w),
        .busy_out (tx_busy_w),
        .txd_out  (tx_txd_w)
    );
    // line idles high when nothing is sent or tx disabled
    assign txd_out = (te_w && tx_busy_w) ? tx_txd_w : 1'b1;

    // nothing queued and nothing on the line
    wire tx_quiet_w = !tx_busy_w && !go_w && !tx_full_r && !pre_r && !sbk_w;
    // queueing data, preamble or break
    wire te_rise_w  = te_w && !te_d_r;
    wire queue_w    = dl_wr_w || te_rise_w || sbk_w;

    // receive side
    wire       rx_done_w;     // frame stop bit sampled
    wire [8:0] rx_word_w;     // frame data
    wire       rx_stop_ok_w;  // stop bit was one
    wire       rx_noise_w;    // samples disagreed
    wire       rx_idle_w;     // idle character seen

    // reception blocked while a framing error stands
    usfl_rx_shift u_rx (
        .clk_in      (sys_clk_in),
        .rst_n_in    (rst_sync_n_r),
        .tick_in     (tick_r),
        .en_in       (re_w && !fe_r),
        .nine_in     (nine_w),
        .rxd_in      (rxd_in),
        .done_out    (rx_done_w),
        .data_out    (rx_word_w),
        .stop_ok_out (rx_stop_ok_w),
        .noise_out   (rx_noise_w),
        .idle_out    (rx_idle_w)
    );

    // parity of the whole field incl parity bit against the type
    wire rx_ones_w = nine_w ? (^rx_word_w) : (^rx_word_w[7:0]);
    wire rx_perr_w = pen_w && (rx_ones_w != podd_w);
    // a held character or standing overrun rejects the new one
    wire rx_over_w = rx_done_w && (rx_holding_full_flag_r || or_r);
    wire rx_take_w = rx_done_w && !rx_holding_full_flag_r && !or_r;

    // flag next values: hardware set beats software clear except tc
    reg tx_holding_empty_flag_nxt, tc_nxt, rx_holding_full_flag_nxt, idle_nxt, or_nxt, nf_nxt, fe_nxt, pf_nxt;
    always @* begin
        // transmit empty: shifter load wins over the clear
        tx_holding_empty_flag_nxt = tx_holding_empty_flag_r;
        if (dgo_w)
            tx_holding_empty_flag_nxt = 1'b1;
        else if (clr_tx_holding_empty_flag_w)
            tx_holding_empty_flag_nxt = 1'b0;
        // transmit complete: any clear or busy term wins
        tc_nxt = tc_r;
        if (tx_holding_empty_flag_nxt && tx_quiet_w)
            tc_nxt = 1'b1;
        if (tx_busy_w || go_w)
            tc_nxt = 1'b0;
        if (clr_tc_w || queue_w)
            tc_nxt = 1'b0;
        // receive full
        rx_holding_full_flag_nxt = rx_holding_full_flag_r;
        if (rx_take_w)
            rx_holding_full_flag_nxt = 1'b1;
        else if (clr_rx_holding_full_flag_w)
            rx_holding_full_flag_nxt = 1'b0;
        // idle line, held off in standby
        idle_nxt = idle_r;
        if (rx_idle_w && idle_ok_r && !rwu_w)
            idle_nxt = 1'b1;
        else if (clr_idle_w)
            idle_nxt = 1'b0;
        // overrun stands until its own armed clear
        or_nxt = or_r;
        if (rx_over_w)
            or_nxt = 1'b1;
        else if (clr_or_w)
            or_nxt = 1'b0;
        // noise, only with a taken frame
        nf_nxt = nf_r;
        if (rx_take_w && rx_noise_w)
            nf_nxt = 1'b1;
        else if (clr_nf_w)
            nf_nxt = 1'b0;
        // framing error, only with a taken frame
        fe_nxt = fe_r;
        if (rx_take_w && !rx_stop_ok_w)
            fe_nxt = 1'b1;
        else if (clr_fe_w)
            fe_nxt = 1'b0;
        // parity error, only with a taken frame
        pf_nxt = pf_r;
        if (rx_take_w && rx_perr_w)
            pf_nxt = 1'b1;
        else if (clr_pf_w)
            pf_nxt = 1'b0;
    end

    // flag registers and their arming
    always @(posedge sys_clk_in or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            {tx_holding_empty_flag_r, tc_r, rx_holding_full_flag_r, idle_r, or_r, nf_r, fe_r, pf_r} <= `USFL_STAT_RST;
            armed_r   <= 8'h00;
            idle_ok_r <= 1'b1;
        end else begin
            tx_holding_empty_flag_r <= tx_holding_empty_flag_nxt;
            tc_r   <= tc_nxt;
            rx_holding_full_flag_r <= rx_holding_full_flag_nxt;
            idle_r <= idle_nxt;
            or_r   <= or_nxt;
            nf_r   <= nf_nxt;
            fe_r   <= fe_nxt;
            pf_r   <= pf_nxt;
            // a status read arms the flags it saw set
            if (st_rd_w)
                armed_r <= stat_w;
            else if (dl_rd_w)
                armed_r <= armed_r & 8'hC0;
            else if (dl_wr_w)
                armed_r <= armed_r & 8'h3F;
            // idle rearmed only by a freshly full receive register
            if (rx_take_w)
                idle_ok_r <= 1'b1;
            else if (clr_idle_w)
                idle_ok_r <= 1'b0;
        end
    end

    // received data kept on overrun, new character dropped
    always @(posedge sys_clk_in or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r)
            rx_data_r <= 9'h000;
        else if (rx_take_w)
            rx_data_r <= rx_word_w;
    end

    // bus address phase capture, read data from flops
    always @(posedge sys_clk_in or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            wr_pend_r  <= 1'b0;
            wa_r       <= 8'h00;
            hrdata_out <= 32'h00000000;
        end else begin
            wr_pend_r <= acc_w && hwrite_in;
            if (acc_w)
                wa_r <= haddr_in;
            if (rd_w) begin
                // unmapped words read as zero
                if (sel(haddr_in, `USFL_OFS_STAT))
                    hrdata_out <= {24'h000000, stat_w};
                else if (sel(haddr_in, `USFL_OFS_CTRL))
                    hrdata_out <= {24'h000000, ctrl_r};
                else if (sel(haddr_in, `USFL_OFS_CFG))
                    hrdata_out <= {29'h00000000, cfg_r};
                else if (sel(haddr_in, `USFL_OFS_DLOW))
                    hrdata_out <= {24'h000000, rx_data_r[7:0]};
                else if (sel(haddr_in, `USFL_OFS_DHIGH))
                    hrdata_out <= {24'h000000, rx_data_r[8], tx_hold_r[8], 6'h00};
                else if (sel(haddr_in, `USFL_OFS_BAUD))
                    hrdata_out <= {16'h0000, baud_r};
                else
                    hrdata_out <= 32'h00000000;
            end
        end
    end

    // register writes in the data phase; status writes do nothing
    always @(posedge sys_clk_in or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            ctrl_r    <= `USFL_CTRL_RST;
            cfg_r     <= `USFL_CFG_RST;
            baud_r    <= `USFL_BAUD_RST;
            tx_hold_r <= 9'h000;
            tx_full_r <= 1'b0;
            pre_r     <= 1'b0;
            te_d_r    <= 1'b0;
        end else begin
            te_d_r <= te_w;
            if (ct_wr_w)
                ctrl_r <= hwdata_in[7:0];
            if (cf_wr_w)
                cfg_r <= hwdata_in[2:0];
            if (bd_wr_w)
                baud_r <= hwdata_in[15:0];
            if (dh_wr_w)
                tx_hold_r[8] <= hwdata_in[`USFL_DH_T8];
            // preamble queued on enable, dropped once loaded
            if (te_rise_w)
                pre_r <= 1'b1;
            else if (go_w && pre_r)
                pre_r <= 1'b0;
            // data write queues a character, shifter load frees it
            if (dl_wr_w) begin
                tx_hold_r[7:0] <= hwdata_in[7:0];
                tx_full_r      <= 1'b1;
            end else if (dgo_w) begin
                tx_full_r <= 1'b0;
            end
        end
    end

    // interrupt requests, one enable per source group
    assign irq_req_out = (ctrl_r[`USFL_CT_TIE] && tx_holding_empty_flag_r)
                      || (ctrl_r[`USFL_CT_TX_DONE_IRQ_ENABLE] && tc_r)
                      || (ctrl_r[`USFL_CT_RIE] && !rwu_w && (rx_holding_full_flag_r || or_r))
                      || (ctrl_r[`USFL_CT_IDLE_LINE_IRQ_ENABLE] && idle_r);

    // hsize only ever whole words here
    wire unused_w = &{1'b0, hsize_in, hwdata_in[31:16]};
endmodule // usfl_top
`default_nettype wire

// [testbench/usfl_checker.sv]
// port assertions for the uart status flag logic
`timescale 1ns/1ps
`default_nettype none
module usfl_checker (
    input wire logic        sys_clk_in,
    input wire logic        rst_n_in,
    input wire logic        hsel_in,
    input wire logic [7:0]  haddr_in,
    input wire logic [1:0]  htrans_in,
    input wire logic        hwrite_in,
    input wire logic        hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic        hreadyout_out,
    input wire logic        hresp_out,
    input wire logic        txd_out,
    input wire logic        irq_req_out
);
    logic stat_q;  // status read now in data phase
    logic unm_q;   // unmapped read now in data phase
    wire  rd_req = hsel_in && htrans_in[1] && hready_in && !hwrite_in;
    // remember which read owns the current data phase
    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stat_q <= 1'b0;
            unm_q  <= 1'b0;
        end else begin
            stat_q <= rd_req && haddr_in == 8'h00;
            unm_q  <= rd_req && haddr_in >= 8'h18;
        end
    end
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_stat; stat_q; endsequence
    sequence s_tc_set; stat_q && hrdata_out[6]; endsequence
    upper_zero_a: assert property (s_stat |-> hrdata_out[31:8] == 24'h0) else $error("status upper bits set");
    tc_tx_holding_empty_flag_a: assert property (s_tc_set |-> hrdata_out[7]) else $error("complete without empty");
    tc_line_a: assert property (s_tc_set |-> txd_out) else $error("line not idle while complete");
    busy_tc_a: assert property (stat_q && !txd_out |-> !hrdata_out[6]) else $error("complete while sending");
    err_full_a: assert property (stat_q && |hrdata_out[2:0] |-> hrdata_out[5]) else $error("error without full");
    unmapped_a: assert property (unm_q |-> hrdata_out == 32'h0) else $error("unmapped read not zero");
    bus_okay_a: assert property (hreadyout_out && !hresp_out) else $error("bus not ready or okay");
    rst_quiet_a: assert property ($rose(rst_n_in) |-> (txd_out && !irq_req_out) [*2]) else $error("busy at reset");
endmodule // usfl_checker
`default_nettype wire

// [testbench/usfl_partner.sv]
// remote serial sender driving the receive pin
`timescale 1ns/1ps
`default_nettype none
module usfl_partner (
    input  wire logic clk_in,
    output var  logic rxd_out
);
    initial rxd_out = 1'b1;  // line rests high between frames
    // start, eight bits lsb first, stop; a zero stop makes a framing fault
    task send(input logic [7:0] d, input logic stp);
        integer     i;
        logic [9:0] f;
        f = {stp, d, 1'b0};
        for (i = 0; i < 10; i = i + 1) begin
            rxd_out <= f[i];
            repeat (16) @(posedge clk_in);
        end
        rxd_out <= 1'b1;
    endtask
endmodule // usfl_partner
`default_nettype wire

// [testbench/usfl_tb_top.sv]
// self-checking bench for the uart status flag logic
`timescale 1ns/1ps
`default_nettype none
module usfl_tb_top;
    logic        clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, rxd;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, hrdata, q;
    wire         hrdy, txd, irq;
    integer      errors = 0, cmp_count = 0;
    always #50 clk = ~clk;
    usfl_partner u_usfl_partner (.clk_in(clk), .rxd_out(rxd));
    usfl_top u_usfl_top (.sys_clk_in(clk), .rst_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hrdy),
        .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(), .rxd_in(rxd), .txd_out(txd), .irq_req_out(irq));
    task give_verdict;
        if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // bounded wait for hready sampled high at a rising edge
    task edge_rdy;
        integer n;
        n = 0;
        @(posedge clk);
        while (hrdy !== 1'b1) begin
            n = n + 1;
            if (n > 20) begin
                errors = errors + 1;
                give_verdict;
            end
            @(posedge clk);
        end
    endtask
    // one single word transfer; read data lands in q
    task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w;
        edge_rdy;
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        edge_rdy;
        q = hrdata;
    endtask
    task st(input logic [7:0] m, input logic [7:0] e);
        bus(8'h00, 1'b0, 32'h0);
        chk({24'h0, q[7:0] & m}, {24'h0, e});
    endtask
    task rx(input logic [7:0] d, input logic s);
        u_usfl_partner.send(d, s);
        repeat (4) @(posedge clk);
    endtask
    task t_reset;  // flags after reset, status write ignored, unmapped read
        st(8'hFF, 8'hC0);
        bus(8'h00, 1'b1, 32'h3F);
        st(8'hFF, 8'hC0);
        bus(8'h18, 1'b0, 32'h0);
        chk(q, 32'h0);
        bus(8'h04, 1'b1, 32'h80);
        @(posedge clk);
        chk({31'h0, irq}, 32'h1);
    endtask
    task t_tx;  // preamble, then one character on the line
        integer     n;
        logic [8:0] cap;
        bus(8'h14, 1'b1, 32'h1);
        bus(8'h04, 1'b1, 32'h0C);
        repeat (2) @(posedge clk);
        st(8'hC0, 8'h80);
        repeat (200) @(posedge clk);
        st(8'hC0, 8'hC0);
        bus(8'h0C, 1'b1, 32'h55);
        n = 0;
        while (txd !== 1'b0 && n < 60) begin @(posedge clk); n = n + 1; end
        repeat (8) @(posedge clk);
        for (n = 0; n < 9; n = n + 1) begin repeat (16) @(posedge clk); cap[n] = txd; end
        chk({23'h0, cap}, 32'h155);
        repeat (20) @(posedge clk);
        st(8'hC0, 8'hC0);
    endtask
    task t_rx;  // clean frame, then overrun seen only after the data read
        rx(8'hA5, 1'b1);
        st(8'h2F, 8'h20);
        bus(8'h0C, 1'b0, 32'h0);
        chk(q, 32'hA5);
        rx(8'h11, 1'b1);
        st(8'h2F, 8'h20);
        rx(8'h22, 1'b1);
        bus(8'h0C, 1'b0, 32'h0);
        chk(q, 32'h11);
        st(8'h2F, 8'h08);
        bus(8'h0C, 1'b0, 32'h0);
        st(8'h2F, 8'h00);
    endtask
    task t_err;  // framing error blocks reception; parity check
        rx(8'h3C, 1'b0);
        st(8'h2F, 8'h22);
        rx(8'h44, 1'b1);
        st(8'h2F, 8'h22);
        bus(8'h0C, 1'b0, 32'h0);
        bus(8'h08, 1'b1, 32'h2);
        rx(8'h01, 1'b1);
        st(8'h2F, 8'h21);
        bus(8'h0C, 1'b0, 32'h0);
        rx(8'h81, 1'b1);
        st(8'h2F, 8'h20);
        bus(8'h0C, 1'b0, 32'h0);
    endtask
    task t_idle;  // idle after ones, not rearmed by an overrun frame, held off in standby
        repeat (200) @(posedge clk);
        st(8'h10, 8'h10);
        rx(8'h00, 1'b1);
        bus(8'h0C, 1'b0, 32'h0);
        rx(8'h00, 1'b1);
        repeat (200) @(posedge clk);
        st(8'h10, 8'h00);
        st(8'h28, 8'h28);
        bus(8'h0C, 1'b0, 32'h0);
        bus(8'h04, 1'b1, 32'h0E);
        rx(8'h5A, 1'b1);
        repeat (200) @(posedge clk);
        st(8'h30, 8'h20);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset;
        t_tx;
        t_rx;
        t_err;
        t_idle;
        give_verdict;
    end
endmodule // usfl_tb_top
bind usfl_top usfl_checker u_usfl_checker (.sys_clk_in, .rst_n_in, .hsel_in, .haddr_in, .htrans_in,
    .hwrite_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out, .txd_out, .irq_req_out);
`default_nettype wire
